// file: shared/cfdb_map.svh
// Address map, field positions and reset values of the control flags and data buffer
`ifndef CFDB_MAP_SVH
`define CFDB_MAP_SVH
// ------------------------------------------------------------
// Address pages (byte address bit 8) and register indexes
// ------------------------------------------------------------
`define CFDB_PAGE_BIT 8
`define CFDB_PAGE_DBUF 1'b0
`define CFDB_PAGE_CTRL 1'b1
`define CFDB_IDX_DBUF_HIGH 6'h0C
`define CFDB_IDX_DBUF_UMID 6'h0D
`define CFDB_IDX_DBUF_LMID 6'h0E
`define CFDB_IDX_DBUF_LOW 6'h0F
`define CFDB_IDX_PIN_LEVEL 6'h0F
`define CFDB_IDX_TIMER_CARRY 6'h17
`define CFDB_IDX_EDGE_SEL 6'h1F
`define CFDB_IDX_IRQ_ENABLE 6'h2F
`define CFDB_IDX_P1B_DIR 6'h35
`define CFDB_IDX_P0B_DIR 6'h36
`define CFDB_IDX_P0A_DIR 6'h37
`define CFDB_IDX_IRQ_REQUEST 6'h3F
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CFDB_BIT_EXT_LEVEL 0
`define CFDB_BIT_VSYNC_LEVEL 2
`define CFDB_BIT_CARRY 0
`define CFDB_BIT_EDGE_SEL 0
// ------------------------------------------------------------
// Reset values and bus answers
// ------------------------------------------------------------
`define CFDB_RST_NIBBLE 4'h0
`define CFDB_RST_DBUF 16'h0000
`define CFDB_RESP_OKAY 2'h0
`define CFDB_RESP_SLVERR 2'h2
`endif

// file: shared/cfdb_pkg.sv
// Types shared by the control flags and data buffer block
package cfdb_pkg;
  // Request, accept and enable groups; bit 0 ext pin .. bit 3 serial
  typedef struct packed {
    logic serial;
    logic vsync;
    logic timer;
    logic ext;
  } cfdb_irq_t;

  typedef struct packed {
    logic [3:0] p0a;
    logic [3:0] p0b;
    logic [3:0] p1b;
  } cfdb_dirs_t;

  typedef struct packed {
    logic hit;
    logic ctrl;
    logic [5:0] idx;
  } cfdb_dec_t;

  typedef enum logic [2:0] {
    CFDB_RD_IDLE = 3'b001,
    CFDB_RD_FETCH = 3'b010,
    CFDB_RD_RESP = 3'b100
  } cfdb_rd_state_t;
endpackage : cfdb_pkg

// file: src/cfdb_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cfdb_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("cfdb_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : cfdb_sync

// file: src/cfdb_dbuf.sv
// Sixteen-bit data buffer held as four nibble words, two access ports
`timescale 1ns/1ps
`include "cfdb_map.svh"
module cfdb_dbuf (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cpu_we,
  input wire logic [1:0] cpu_widx,
  input wire logic [3:0] cpu_wdata,
  input wire logic [1:0] cpu_ridx,
  output logic [3:0] cpu_rdata,
  input wire logic per_we,
  input wire logic [15:0] per_wdata,
  output logic [15:0] per_rdata
);
  // Word 0 sits at 0CH and carries the MSB nibble
  logic [3:0] word [0:3];
  logic [15:0] flat;

  assign flat = {word[0], word[1], word[2], word[3]};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        word[i] <= `CFDB_RST_NIBBLE;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        // A bus write to the same word beats a peripheral load
        if (cpu_we && cpu_widx == 2'(i)) begin
          word[i] <= cpu_wdata;
        end else if (per_we) begin
          word[i] <= per_wdata[15-4*i -: 4];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cpu_rdata <= `CFDB_RST_NIBBLE;
      per_rdata <= `CFDB_RST_DBUF;
    end else begin
      cpu_rdata <= word[cpu_ridx];
      per_rdata <= flat;
    end
  end

  a_dbuf_lsb_word: assert property (@(posedge clk_sys) disable iff (reset)
    per_we && !cpu_we |=> word[3] == $past(per_wdata[3:0]) && word[0] == $past(per_wdata[15:12]))
    else $error("peripheral load misplaced nibbles");
endmodule : cfdb_dbuf

// file: src/cfdb_top.sv
// Control flags, interrupt requests, port directions and data buffer over AXI4-Lite
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cfdb_map.svh"
module cfdb_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and event sources
  input wire logic ext_int_pin,
  input wire logic vsync_pin,
  input wire logic time_base_tick,
  input wire logic serial_event,
  input wire cfdb_pkg::cfdb_irq_t irq_accept,
  // Peripheral side of the data buffer
  input wire logic per_load,
  input wire logic [15:0] per_load_data,
  output logic [15:0] per_data,
  // Results
  output cfdb_pkg::cfdb_irq_t irq_pending,
  output logic irq_dispatch,
  output cfdb_pkg::cfdb_dirs_t port_dirs
);
  if (ADDR_W < 10) begin : g_bad_addr_w
    $error("cfdb_top: ADDR_W must be at least 10");
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic cfdb_pkg::cfdb_dec_t decode(input logic [ADDR_W-1:0] a);
    cfdb_pkg::cfdb_dec_t d;
    logic known;
    d.idx = a[7:2];
    d.ctrl = a[`CFDB_PAGE_BIT];
    case (d.idx)
      `CFDB_IDX_PIN_LEVEL, `CFDB_IDX_TIMER_CARRY, `CFDB_IDX_EDGE_SEL,
      `CFDB_IDX_IRQ_ENABLE, `CFDB_IDX_P1B_DIR, `CFDB_IDX_P0B_DIR,
      `CFDB_IDX_P0A_DIR, `CFDB_IDX_IRQ_REQUEST: known = 1'b1;
      default: known = 1'b0;
    endcase
    if (d.ctrl == `CFDB_PAGE_DBUF) begin
      known = d.idx >= `CFDB_IDX_DBUF_HIGH && d.idx <= `CFDB_IDX_DBUF_LOW;
    end
    d.hit = known && a[ADDR_W-1:`CFDB_PAGE_BIT+1] == '0;
    return d;
  endfunction : decode

  function automatic logic is_ctrl(input cfdb_pkg::cfdb_dec_t d, input logic [5:0] idx);
    return d.hit && d.ctrl == `CFDB_PAGE_CTRL && d.idx == idx;
  endfunction : is_ctrl

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic ext_level;
  logic vsync_level;
  logic ext_prev;
  logic vsync_prev;

  cfdb_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({vsync_pin, ext_int_pin}),
    .sync_out({vsync_level, ext_level})
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ext_prev <= 1'b0;
      vsync_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
      vsync_prev <= vsync_level;
    end
  end

  // ------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [3:0] w_nib;
  logic w_lane0;
  logic do_write;
  logic next_aw_got;
  logic next_w_got;
  logic next_bvalid;
  cfdb_pkg::cfdb_dec_t wr_dec;
  logic wr_ok;

  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_dec = decode(aw_addr);
  // Only the low byte lane carries the nibble
  assign wr_ok = do_write && w_lane0;
  assign next_aw_got = (aw_got || (s_axi_awvalid && s_axi_awready)) && !do_write;
  assign next_w_got = (w_got || (s_axi_wvalid && s_axi_wready)) && !do_write;
  assign next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_nib <= `CFDB_RST_NIBBLE;
      w_lane0 <= 1'b0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_nib <= s_axi_wdata[3:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  // One write at a time: no new address or data until the response is taken
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFDB_RESP_OKAY;
    end else begin
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready <= !next_w_got && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= wr_dec.hit ? `CFDB_RESP_OKAY : `CFDB_RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [3:0] edge_sel;
  cfdb_pkg::cfdb_irq_t irq_enable;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      edge_sel <= `CFDB_RST_NIBBLE;
    end else if (wr_ok && is_ctrl(wr_dec, `CFDB_IDX_EDGE_SEL)) begin
      edge_sel <= w_nib;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_enable <= `CFDB_RST_NIBBLE;
    end else if (wr_ok && is_ctrl(wr_dec, `CFDB_IDX_IRQ_ENABLE)) begin
      irq_enable <= w_nib;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_dirs <= '0;
    end else if (wr_ok) begin
      if (is_ctrl(wr_dec, `CFDB_IDX_P1B_DIR)) begin
        port_dirs.p1b <= w_nib;
      end
      if (is_ctrl(wr_dec, `CFDB_IDX_P0B_DIR)) begin
        port_dirs.p0b <= w_nib;
      end
      if (is_ctrl(wr_dec, `CFDB_IDX_P0A_DIR)) begin
        port_dirs.p0a <= w_nib;
      end
    end
  end

  // ------------------------------------------------------------
  // Timer carry and interrupt requests
  // ------------------------------------------------------------
  cfdb_pkg::cfdb_rd_state_t rd_state;
  cfdb_pkg::cfdb_rd_state_t next_rd_state;
  cfdb_pkg::cfdb_dec_t rd_dec;
  logic timer_carry;
  logic carry_read;
  logic edge_fall;
  cfdb_pkg::cfdb_irq_t hw_set;
  cfdb_pkg::cfdb_irq_t sw_set;
  cfdb_pkg::cfdb_irq_t irq_clr;
  cfdb_pkg::cfdb_irq_t irq_req;

  assign carry_read = rd_state == cfdb_pkg::CFDB_RD_FETCH &&
                      is_ctrl(rd_dec, `CFDB_IDX_TIMER_CARRY);

  // A tick in the same cycle as the clearing read still leaves the flag set
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      timer_carry <= 1'b0;
    end else begin
      timer_carry <= time_base_tick || (timer_carry && !carry_read);
    end
  end

  assign edge_fall = edge_sel[`CFDB_BIT_EDGE_SEL];
  always_comb begin
    hw_set.ext = edge_fall ? (ext_prev && !ext_level) : (!ext_prev && ext_level);
    hw_set.vsync = edge_fall ? (vsync_prev && !vsync_level) : (!vsync_prev && vsync_level);
    hw_set.timer = time_base_tick;
    hw_set.serial = serial_event;
  end

  assign sw_set = (wr_ok && is_ctrl(wr_dec, `CFDB_IDX_IRQ_REQUEST)) ? w_nib : '0;
  assign irq_clr = irq_accept |
                   ((wr_ok && is_ctrl(wr_dec, `CFDB_IDX_IRQ_REQUEST)) ? ~w_nib : '0);

  // Sets win over clears so that no request is lost
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_req <= `CFDB_RST_NIBBLE;
    end else begin
      irq_req <= hw_set | sw_set | (irq_req & ~irq_clr);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_pending <= '0;
      irq_dispatch <= 1'b0;
    end else begin
      irq_pending <= irq_req & irq_enable;
      irq_dispatch <= |(irq_req & irq_enable);
    end
  end

  // ------------------------------------------------------------
  // Data buffer
  // ------------------------------------------------------------
  logic [3:0] dbuf_rdata;
  logic [1:0] dbuf_ridx;
  logic dbuf_we;

  assign dbuf_we = wr_ok && wr_dec.hit && wr_dec.ctrl == `CFDB_PAGE_DBUF;
  assign dbuf_ridx = rd_state == cfdb_pkg::CFDB_RD_IDLE ? s_axi_araddr[3:2] : rd_dec.idx[1:0];

  cfdb_dbuf u_dbuf (
    .clk_sys(clk_sys),
    .reset(reset),
    .cpu_we(dbuf_we),
    .cpu_widx(wr_dec.idx[1:0]),
    .cpu_wdata(w_nib),
    .cpu_ridx(dbuf_ridx),
    .cpu_rdata(dbuf_rdata),
    .per_we(per_load),
    .per_wdata(per_load_data),
    .per_rdata(per_data)
  );

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic [3:0] rd_nib;
  logic [ADDR_W-1:0] rd_addr;

  assign rd_dec = decode(rd_addr);

  always_comb begin
    next_rd_state = rd_state;
    unique case (rd_state)
      cfdb_pkg::CFDB_RD_IDLE: begin
        // Ready is still low on the first edge after reset; wait for a real handshake
        if (s_axi_arvalid && s_axi_arready) begin
          next_rd_state = cfdb_pkg::CFDB_RD_FETCH;
        end
      end
      cfdb_pkg::CFDB_RD_FETCH: begin
        next_rd_state = cfdb_pkg::CFDB_RD_RESP;
      end
      cfdb_pkg::CFDB_RD_RESP: begin
        if (s_axi_rready) begin
          next_rd_state = cfdb_pkg::CFDB_RD_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    rd_nib = `CFDB_RST_NIBBLE;
    if (rd_dec.ctrl == `CFDB_PAGE_DBUF) begin
      rd_nib = dbuf_rdata;
    end else begin
      case (rd_dec.idx)
        `CFDB_IDX_PIN_LEVEL: begin
          rd_nib[`CFDB_BIT_EXT_LEVEL] = ext_level;
          rd_nib[`CFDB_BIT_VSYNC_LEVEL] = vsync_level;
        end
        `CFDB_IDX_TIMER_CARRY: rd_nib[`CFDB_BIT_CARRY] = timer_carry;
        `CFDB_IDX_EDGE_SEL: rd_nib = edge_sel;
        `CFDB_IDX_IRQ_ENABLE: rd_nib = irq_enable;
        `CFDB_IDX_P1B_DIR: rd_nib = port_dirs.p1b;
        `CFDB_IDX_P0B_DIR: rd_nib = port_dirs.p0b;
        `CFDB_IDX_P0A_DIR: rd_nib = port_dirs.p0a;
        `CFDB_IDX_IRQ_REQUEST: rd_nib = irq_req;
        default: rd_nib = `CFDB_RST_NIBBLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_state <= cfdb_pkg::CFDB_RD_IDLE;
      rd_addr <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CFDB_RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      s_axi_arready <= next_rd_state == cfdb_pkg::CFDB_RD_IDLE;
      s_axi_rvalid <= next_rd_state == cfdb_pkg::CFDB_RD_RESP;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
      end
      if (rd_state == cfdb_pkg::CFDB_RD_FETCH) begin
        s_axi_rdata <= rd_dec.hit ? {28'h0000000, rd_nib} : 32'h00000000;
        s_axi_rresp <= rd_dec.hit ? `CFDB_RESP_OKAY : `CFDB_RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_pin_level_read: assert property (
    carry_read == 1'b0 && rd_state == cfdb_pkg::CFDB_RD_FETCH &&
    is_ctrl(rd_dec, `CFDB_IDX_PIN_LEVEL) |=> s_axi_rdata[0] == $past(ext_level))
    else $error("pin level read does not follow the pin");

  a_carry_clear: assert property (
    carry_read && !time_base_tick |=> !timer_carry ##0 s_axi_rdata[0] == $past(timer_carry))
    else $error("timer carry not cleared by its read");

  a_carry_set: assert property (
    time_base_tick |=> timer_carry)
    else $error("timer carry missed a tick");

  a_edge_select: assert property (
    $rose(ext_level) && !edge_fall |=> irq_req.ext)
    else $error("rising edge did not raise the ext request");

  a_dispatch_gate: assert property (
    !irq_enable.timer && !irq_enable.ext && !irq_enable.vsync && !irq_enable.serial
    |=> !irq_dispatch)
    else $error("dispatch without any enabled source");

  a_accept_clear: assert property (
    irq_accept.timer && !time_base_tick && sw_set == '0 |=> !irq_req.timer)
    else $error("accepted timer request not cleared");

  a_soft_request: assert property (
    wr_ok && is_ctrl(wr_dec, `CFDB_IDX_IRQ_REQUEST) && w_nib[3] |=> irq_req.serial ##1 irq_pending.serial == irq_enable.serial)
    else $error("software request not raised");

  a_dir_write: assert property (
    wr_ok && is_ctrl(wr_dec, `CFDB_IDX_P1B_DIR) |=> port_dirs.p1b == $past(w_nib))
    else $error("port 1B direction not written");

  a_write_resp: assert property (
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");
endmodule : cfdb_top

// file: verif/cfdb_tb.sv
// Self-checking testbench for the control flags and data buffer block
`timescale 1ns/1ps
module testbench;
  logic clk_sys;
  logic reset;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic ext_int_pin;
  logic vsync_pin;
  logic time_base_tick;
  logic serial_event;
  cfdb_pkg::cfdb_irq_t irq_accept;
  logic per_load;
  logic [15:0] per_load_data;
  logic [15:0] per_data;
  cfdb_pkg::cfdb_irq_t irq_pending;
  logic irq_dispatch;
  cfdb_pkg::cfdb_dirs_t port_dirs;
  int err_total;
  int compares;
  localparam logic [11:0] A_PIN = 12'h13C;
  localparam logic [11:0] A_CARRY = 12'h15C;
  localparam logic [11:0] A_EDGE = 12'h17C;
  localparam logic [11:0] A_EN = 12'h1BC;
  localparam logic [11:0] A_REQ = 12'h1FC;
  localparam logic [11:0] A_BAD = 12'h004;
  localparam logic [11:0] REGS [12] = '{12'h030, 12'h034, 12'h038, 12'h03C, A_PIN, A_CARRY,
    A_EDGE, A_EN, 12'h1D4, 12'h1D8, 12'h1DC, A_REQ};

  cfdb_top dut (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ext_int_pin(ext_int_pin), .vsync_pin(vsync_pin),
    .time_base_tick(time_base_tick), .serial_event(serial_event), .irq_accept(irq_accept),
    .per_load(per_load), .per_load_data(per_load_data), .per_data(per_data),
    .irq_pending(irq_pending), .irq_dispatch(irq_dispatch), .port_dirs(port_dirs));

  // ------------------------------------------------------------
  // Clock, verdict and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("counts: compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // The whole sequence needs well under the 10000-cycle watchdog limit
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Ready answers are held high; the response is taken at the valid edge
  task automatic wr(input logic [11:0] a, input logic [3:0] d, input logic [3:0] s,
      input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {28'h0000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (aw || w) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (!s_axi_bvalid) begin
      @(posedge clk_sys);
    end
    chk(s_axi_bresp, er, "write response");
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [3:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge clk_sys);
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, {28'h0000000, e}, "read data");
    chk(s_axi_rresp, er, "read response");
  endtask : rchk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    foreach (REGS[i]) rchk(REGS[i], 4'h0, 2'h0);
    chk(port_dirs, 12'h000, "dirs at reset");
    chk(per_data, 16'h0000, "buffer at reset");
  endtask : t_reset

  task automatic t_dirs;
    wr(12'h1D4, 4'hA, 4'hF, 2'h0);
    wr(12'h1D8, 4'h5, 4'hF, 2'h0);
    wr(12'h1DC, 4'hC, 4'hF, 2'h0);
    wr(12'h1DC, 4'h3, 4'h0, 2'h0);
    chk(port_dirs, 12'hC5A, "port directions");
    rchk(12'h1DC, 4'hC, 2'h0);
  endtask : t_dirs

  task automatic t_dbuf;
    for (int i = 0; i < 4; i++) wr(12'h030 + 12'(4 * i), 4'(i + 1), 4'hF, 2'h0);
    // The peripheral copy trails the last word write by one edge
    @(posedge clk_sys);
    chk(per_data, 16'h1234, "buffer word order");
    per_load_data <= 16'hABCD;
    per_load <= 1'h1;
    @(posedge clk_sys);
    per_load <= 1'h0;
    for (int i = 0; i < 4; i++) rchk(12'h030 + 12'(4 * i), 4'(10 + i), 2'h0);
    chk(per_data, 16'hABCD, "peripheral load");
  endtask : t_dbuf

  task automatic pins(input logic v, input logic [3:0] req);
    ext_int_pin <= v;
    vsync_pin <= v;
    repeat (6) @(posedge clk_sys);
    rchk(A_PIN, v ? 4'h5 : 4'h0, 2'h0);
    rchk(A_REQ, req, 2'h0);
    wr(A_REQ, 4'h0, 4'hF, 2'h0);
  endtask : pins

  task automatic t_edge;
    pins(1'h1, 4'h5);
    rchk(A_REQ, 4'h0, 2'h0);
    pins(1'h0, 4'h0);
    wr(A_EDGE, 4'h1, 4'hF, 2'h0);
    pins(1'h1, 4'h0);
    pins(1'h0, 4'h5);
  endtask : t_edge

  task automatic t_timer;
    time_base_tick <= 1'h1;
    @(posedge clk_sys);
    time_base_tick <= 1'h0;
    rchk(A_CARRY, 4'h1, 2'h0);
    rchk(A_CARRY, 4'h0, 2'h0);
    rchk(A_REQ, 4'h2, 2'h0);
    irq_accept <= cfdb_pkg::cfdb_irq_t'(4'h2);
    serial_event <= 1'h1;
    @(posedge clk_sys);
    irq_accept <= cfdb_pkg::cfdb_irq_t'(4'h0);
    serial_event <= 1'h0;
    rchk(A_REQ, 4'h8, 2'h0);
  endtask : t_timer

  task automatic t_dispatch;
    wr(A_EN, 4'h0, 4'hF, 2'h0);
    wr(A_REQ, 4'hF, 4'hF, 2'h0);
    repeat (3) @(posedge clk_sys);
    chk({irq_pending, irq_dispatch}, 5'h00, "all blocked");
    wr(A_EN, 4'h4, 4'hF, 2'h0);
    repeat (3) @(posedge clk_sys);
    chk({irq_pending, irq_dispatch}, 5'h09, "vsync permitted");
    irq_accept <= cfdb_pkg::cfdb_irq_t'(4'h4);
    @(posedge clk_sys);
    irq_accept <= cfdb_pkg::cfdb_irq_t'(4'h0);
    repeat (3) @(posedge clk_sys);
    chk({irq_pending, irq_dispatch}, 5'h00, "accepted");
    rchk(A_REQ, 4'hB, 2'h0);
  endtask : t_dispatch

  task automatic t_unmapped;
    wr(A_BAD, 4'h5, 4'hF, 2'h2);
    rchk(A_BAD, 4'h0, 2'h2);
    wr(A_PIN, 4'hF, 4'hF, 2'h0);
    rchk(A_PIN, 4'h0, 2'h0);
  endtask : t_unmapped

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    err_total = 0;
    compares = 0;
    reset = 1'h1;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h1;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h1;
    ext_int_pin = 1'h0;
    vsync_pin = 1'h0;
    time_base_tick = 1'h0;
    serial_event = 1'h0;
    irq_accept = cfdb_pkg::cfdb_irq_t'(4'h0);
    per_load = 1'h0;
    per_load_data = 16'h0000;
    repeat (20) @(posedge clk_sys);
    reset <= 1'h0;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_dirs();
    t_dbuf();
    t_edge();
    t_timer();
    t_dispatch();
    t_unmapped();
    tally_and_finish();
  end
endmodule : testbench
